//--- hw/counter_array_watchdog.sv
// Purpose: Counter array watchdog on module 2 with control and mode registers
// Assumes: Byte register bus on clk_sys, bit writes to the control register
// Notes: Capture/compare modes of modules 0 and 1 live outside; they report matches
// Operation
// [RULE1] Reset when low byte wraps while high byte equals compare byte, watchdog on.
// [RULE2] Writing one to module 2 match flag while enabled forces reset.
// [RULE3] Clock select and idle suspend are frozen while watchdog is enabled.
// [RULE4] Setting enable bit or lock bit enables the watchdog.
// [RULE5] Lock keeps watchdog enabled until next system reset.
// [RULE6] Clearing enable bit disables watchdog when lock is clear.
// [RULE7] Watchdog is enabled after any reset.
// [RULE8] Reset defaults: divide by twelve, low byte zero, offset zero.
// [RULE9] Reset defaults give 256 counter ticks, 3072 system clocks.
// [RULE10] Software disables, selects clock, offset, idle, enables, then writes compare.
// [RULE11] Counter wrap sets sticky overflow flag, requests interrupt if enabled.
// [RULE12] Run bit zero stops counter, one lets it run.
// [RULE13] Control bits five to three read zero, writes ignored.
// [RULE14] Match flags set by hardware, request interrupt, cleared by software.
// [RULE15] Control register at address 0xD8, bit addressable.
// [RULE16] Compare write loads high byte plus offset.
// [RULE17] Enabled watchdog forces counter on, blocks counter byte writes.
// [RULE18] Offset counts low byte overflows allowed before reset.
// [RULE19] Reset request is a one-cycle synchronous pulse.
`timescale 1ns/10ps
module counter_array_watchdog
    import wdog_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [7:0] regAddr, // Register address
    input wire logic regWrEn, // Byte write strobe
    input wire logic [7:0] regWrData, // Byte write data
    input wire logic regRdEn, // Read strobe
    input wire logic bitWrEn, // Single-bit write strobe
    input wire logic [2:0] bitIdx, // Bit index in control register
    input wire logic bitVal, // Bit value
    input wire logic [1:0] moduleMatch, // Match pulses from modules 0 and 1
    input wire logic [2:0] matchIntEn, // Match interrupt enables per module
    input wire logic timer0Ovf, // Timer overflow pulse
    input wire logic extInPin, // External count pin
    input wire logic extClkPin, // External clock pin
    input wire logic cpuIdle, // Processor idle state
    output logic [7:0] regRdData, // Read data, one cycle after strobe
    output logic irqReq, // Interrupt request level
    output logic wdResetReq // Watchdog reset pulse
);
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic [7:0] cntL_r;
    logic [7:0] cntL_nxt;
    logic [7:0] cntH_r;
    logic [7:0] cntH_nxt;
    logic [7:0] offs_r;
    logic [7:0] offs_nxt;
    logic [7:0] cmp_r;
    logic [7:0] cmp_nxt;
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;
    logic irq_r;
    logic irq_nxt;
    logic wdRst_r;
    logic wdRst_nxt;
    logic wdOn;
    logic running;
    logic lowWrap;
    logic ctrlBitWr;
    logic [7:0] ctrlWrVal;
    tick_if tk();

    counter_tick_gen u_tick (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .timer0Ovf(timer0Ovf),
        .extInPin(extInPin),
        .extClkPin(extClkPin),
        .tk(tk)
    );

    // Watchdog state and counter run
    assign wdOn = mode_r[WDEN_BIT];
    assign running = ctrl_r[RUN_BIT] | wdOn; // [RULE12] [RULE17]
    assign tk.sel = mode_r[CLKSEL_LSB +: 3];
    assign tk.hold = ~running | (mode_r[IDLE_BIT] & cpuIdle);
    assign lowWrap = tk.tick & (cntL_r == 8'hff);

    // Byte writes and bit writes both land here; bit write patches one bit
    assign ctrlBitWr = bitWrEn | (regWrEn & (regAddr == CTRL_ADDR)); // [RULE15]
    always_comb
    begin
        ctrlWrVal = regWrData;
        if (bitWrEn)
        begin
            ctrlWrVal = ctrl_r;
            ctrlWrVal[bitIdx] = bitVal;
        end
    end

    // Next-state logic for all registers except the interrupt request
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        mode_nxt = mode_r;
        cntL_nxt = cntL_r;
        cntH_nxt = cntH_r;
        offs_nxt = offs_r;
        cmp_nxt = cmp_r;
        wdRst_nxt = 1'b0;
        rd_nxt = rd_r;
        // Software writes first so hardware sets below win
        if (ctrlBitWr)
        begin
            ctrl_nxt = ctrlWrVal & 8'hc7; // [RULE13]
            // Only a write naming the module 2 flag forces; a bit write elsewhere must not
            if (wdOn && (bitWrEn ? ((bitIdx == 3'(MATCH2_BIT)) && bitVal) : regWrData[MATCH2_BIT]))
            begin
                wdRst_nxt = 1'b1; // [RULE2]
            end
        end
        if (regWrEn)
        begin
            case (regAddr)
                MODE_ADDR:
                begin
                    mode_nxt[ECF_BIT] = regWrData[ECF_BIT];
                    mode_nxt[LOCK_BIT] = mode_r[LOCK_BIT] | regWrData[LOCK_BIT]; // [RULE5]
                    // [RULE4] [RULE5] [RULE6]
                    mode_nxt[WDEN_BIT] = regWrData[WDEN_BIT] | regWrData[LOCK_BIT] | mode_r[LOCK_BIT];
                    if (!wdOn)
                    begin
                        mode_nxt[IDLE_BIT] = regWrData[IDLE_BIT]; // [RULE3]
                        mode_nxt[CLKSEL_LSB +: 3] = regWrData[CLKSEL_LSB +: 3]; // [RULE3]
                    end
                end
                CNTL_ADDR: if (!wdOn) cntL_nxt = regWrData; // [RULE17]
                CNTH_ADDR: if (!wdOn) cntH_nxt = regWrData; // [RULE17]
                OFFS_ADDR: offs_nxt = regWrData;
                CMPH_ADDR: cmp_nxt = cntH_r + offs_r; // [RULE16] [RULE18]
                default: ;
            endcase
        end
        // Counter advance on each selected tick
        if (tk.tick)
        begin
            cntL_nxt = cntL_r + 8'h01;
            if (lowWrap)
            begin
                cntH_nxt = cntH_r + 8'h01;
            end
            if (lowWrap && (cntH_r == 8'hff))
            begin
                ctrl_nxt[OVF_BIT] = 1'b1; // [RULE11]
            end
        end
        // Timeout: offset steps of high byte past the last update
        if (wdOn && lowWrap && (cntH_r == cmp_r))
        begin
            wdRst_nxt = 1'b1; // [RULE1] [RULE9]
        end
        // Module match flags; set beats a clear in the same cycle
        if (moduleMatch[0])
        begin
            ctrl_nxt[0] = 1'b1; // [RULE14]
        end
        if (moduleMatch[1])
        begin
            ctrl_nxt[1] = 1'b1; // [RULE14]
        end
        // Module 2 is a plain 16-bit compare when the watchdog is off
        if (!wdOn && tk.tick && ({cntH_r, cntL_r} == {cmp_r, offs_r}))
        begin
            ctrl_nxt[MATCH2_BIT] = 1'b1; // [RULE14]
        end
        if (regRdEn)
        begin
            case (regAddr)
                CTRL_ADDR: rd_nxt = ctrl_r & 8'hc7; // [RULE13]
                MODE_ADDR: rd_nxt = mode_r & 8'hef;
                CNTL_ADDR: rd_nxt = cntL_r;
                CNTH_ADDR: rd_nxt = cntH_r;
                OFFS_ADDR: rd_nxt = offs_r;
                CMPH_ADDR: rd_nxt = cmp_r;
                default: rd_nxt = 8'h00;
            endcase
        end
    end

    // Interrupt request from sticky flags and their enables
    always_comb
    begin
        irq_nxt = (ctrl_r[OVF_BIT] & mode_r[ECF_BIT]) | (|(ctrl_r[2:0] & matchIntEn)); // [RULE11] [RULE14]
    end

    // Registers only; reset restores watchdog-on defaults
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_r <= CTRL_RESET;
            mode_r <= MODE_RESET; // [RULE7] [RULE8]
            cntL_r <= BYTE_RESET; // [RULE8]
            cntH_r <= BYTE_RESET;
            offs_r <= BYTE_RESET; // [RULE8]
            cmp_r <= BYTE_RESET;
            rd_r <= BYTE_RESET;
            irq_r <= 1'b0;
            wdRst_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            cntL_r <= cntL_nxt;
            cntH_r <= cntH_nxt;
            offs_r <= offs_nxt;
            cmp_r <= cmp_nxt;
            rd_r <= rd_nxt;
            irq_r <= irq_nxt;
            wdRst_r <= wdRst_nxt; // [RULE19]
        end
    end

    assign regRdData = rd_r;
    assign irqReq = irq_r;
    assign wdResetReq = wdRst_r;
endmodule // counter_array_watchdog

//--- hw/wdt_pkg.sv
// Purpose: Shared constants for the counter array watchdog
// Assumes: Byte-wide special function register bus
// Notes: Offsets are register addresses on that bus
package wdog_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'hd8; // array_control_flags
    localparam logic [7:0] MODE_ADDR = 8'hd9; // array_mode_reg
    localparam logic [7:0] CNTL_ADDR = 8'hf9; // counter_low_byte
    localparam logic [7:0] CNTH_ADDR = 8'hfa; // counter_high_byte
    localparam logic [7:0] OFFS_ADDR = 8'hfb; // watchdog_offset_byte
    localparam logic [7:0] CMPH_ADDR = 8'hfc; // watchdog_compare_byte
    // Control register bit positions
    localparam int OVF_BIT = 7;
    localparam int RUN_BIT = 6;
    localparam int MATCH2_BIT = 2;
    // Mode register bit positions
    localparam int IDLE_BIT = 7;
    localparam int WDEN_BIT = 6;
    localparam int LOCK_BIT = 5;
    localparam int CLKSEL_LSB = 1;
    localparam int ECF_BIT = 0;
    localparam logic [7:0] MODE_RESET = 8'h40;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Counter clock selections
    localparam logic [2:0] SEL_DIV12 = 3'h0;
    localparam logic [2:0] SEL_DIV4 = 3'h1;
    localparam logic [2:0] SEL_T0OVF = 3'h2;
    localparam logic [2:0] SEL_PINFALL = 3'h3;
    localparam logic [2:0] SEL_SYSCLK = 3'h4;
    localparam logic [2:0] SEL_EXTDIV8 = 3'h5;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [3:0] EXT8_LAST = 4'h7;
    localparam logic [3:0] PRE_RESET = 4'h0;
endpackage

//--- hw/tick_if.sv
// Purpose: Carrier between watchdog core and its tick generator
// Assumes: One clock domain
// Notes: Tick is high one cycle per count; it stays high on the system clock selection
`timescale 1ns/10ps
interface tick_if;
    logic [2:0] sel;
    logic hold;
    logic tick;
    modport core (output sel, output hold, input tick);
    modport gen (input sel, input hold, output tick);
endinterface

//--- hw/counter_tick_gen.sv
// Purpose: Counter clock tick generator with selectable timebase
// Assumes: Timer overflow pulse is on clk_sys, pins are asynchronous
// Notes: Pins pass two flip-flops before any edge logic
`timescale 1ns/10ps
module counter_tick_gen
    import wdog_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic timer0Ovf, // Timer overflow pulse
    input wire logic extInPin, // External count pin
    input wire logic extClkPin, // External clock pin
    tick_if.gen tk // Tick carrier
);
    logic [1:0] inSync_r;
    logic [1:0] inSync_nxt;
    logic [1:0] clkSync_r;
    logic [1:0] clkSync_nxt;
    logic inLast_r;
    logic inLast_nxt;
    logic clkLast_r;
    logic clkLast_nxt;
    logic [3:0] pre_r;
    logic [3:0] pre_nxt;
    logic tick_r;
    logic tick_nxt;

    // Edge detectors only look at second stage
    always_comb
    begin
        inSync_nxt = {inSync_r[0], extInPin};
        clkSync_nxt = {clkSync_r[0], extClkPin};
        inLast_nxt = inSync_r[1];
        clkLast_nxt = clkSync_r[1];
        pre_nxt = pre_r;
        tick_nxt = 1'b0;
        if (!tk.hold)
        begin
            case (tk.sel)
                SEL_DIV12:
                begin
                    pre_nxt = (pre_r >= DIV12_LAST) ? PRE_RESET : pre_r + 4'h1;
                    tick_nxt = (pre_r >= DIV12_LAST);
                end
                SEL_DIV4:
                begin
                    pre_nxt = (pre_r >= DIV4_LAST) ? PRE_RESET : pre_r + 4'h1;
                    tick_nxt = (pre_r >= DIV4_LAST);
                end
                SEL_T0OVF: tick_nxt = timer0Ovf;
                SEL_PINFALL: tick_nxt = inLast_r & ~inSync_r[1];
                SEL_SYSCLK: tick_nxt = 1'b1;
                SEL_EXTDIV8:
                begin
                    // Rising edges of the synchronised clock are counted
                    if (clkSync_r[1] & ~clkLast_r)
                    begin
                        pre_nxt = (pre_r >= EXT8_LAST) ? PRE_RESET : pre_r + 4'h1;
                        tick_nxt = (pre_r >= EXT8_LAST);
                    end
                end
                default: tick_nxt = 1'b0;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            inSync_r <= 2'h0;
            clkSync_r <= 2'h0;
            inLast_r <= 1'b0;
            clkLast_r <= 1'b0;
            pre_r <= PRE_RESET;
            tick_r <= 1'b0;
        end
        else
        begin
            inSync_r <= inSync_nxt;
            clkSync_r <= clkSync_nxt;
            inLast_r <= inLast_nxt;
            clkLast_r <= clkLast_nxt;
            pre_r <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r;
endmodule // counter_tick_gen

//--- tb/counter_array_watchdog_asserts.sv
// Purpose: Port-level checks of the counter array watchdog
// Assumes: Enable and lock shadowed from mode writes
// Notes: Bound to the design after the module
`timescale 1ns/10ps
module counter_array_watchdog_chk
    import wdog_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic [7:0] regAddr, // Address
    input wire logic regWrEn, // Byte write
    input wire logic [7:0] regWrData, // Write data
    input wire logic regRdEn, // Read strobe
    input wire logic bitWrEn, // Bit write
    input wire logic [2:0] bitIdx, // Bit index
    input wire logic bitVal, // Bit value
    input wire logic [7:0] regRdData, // Read data
    input wire logic wdResetReq // Reset pulse
);
    logic wdOn_r, wdOn_nxt, lock_r, lock_nxt, busy_r, busy_nxt;
    logic [12:0] since_r, since_nxt;
    // Shadow state; busy ends the quiet window after reset
    always_comb
    begin
        lock_nxt = lock_r;
        wdOn_nxt = wdOn_r;
        if (regWrEn && regAddr == MODE_ADDR)
        begin
            lock_nxt = lock_r | regWrData[LOCK_BIT];
            wdOn_nxt = lock_r | regWrData[LOCK_BIT] | regWrData[WDEN_BIT];
        end
        busy_nxt = busy_r | regWrEn | bitWrEn | wdResetReq;
        since_nxt = (since_r == 13'h1fff) ? since_r : since_r + 13'h1; // Saturates, no wrap
    end
    always_ff @(posedge clk_sys)
    begin
        lock_r <= rst_n ? lock_nxt : 1'b0;
        wdOn_r <= rst_n ? wdOn_nxt : 1'b1;
        busy_r <= rst_n ? busy_nxt : 1'b0;
        since_r <= rst_n ? since_nxt : 13'h0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence forceWr;
        bitWrEn && bitIdx == 3'h2 && bitVal && wdOn_r;
    endsequence
    AST_FORCE: assert property (forceWr |=> wdResetReq) else $error("forced reset missing");
    AST_PULSE: assert property (wdResetReq |=> !wdResetReq) else $error("reset pulse too long");
    AST_OFF: assert property (!wdOn_r [*3] |-> !wdResetReq) else $error("reset while disabled");
    AST_CTRL_RD: assert property (regRdEn && regAddr == CTRL_ADDR |=> regRdData[5:3] == 3'h0)
        else $error("unused control bits not zero");
    AST_EN_RD: assert property (regRdEn && !regWrEn && regAddr == MODE_ADDR |=>
        regRdData[WDEN_BIT] == $past(wdOn_r)) else $error("enable bit wrong");
    AST_LOCK_RD: assert property (regRdEn && !regWrEn && regAddr == MODE_ADDR |=>
        regRdData[LOCK_BIT] == $past(lock_r)) else $error("lock bit wrong");
    AST_UNMAP: assert property (regRdEn && regAddr == 8'h00 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    AST_TMO: assert property (wdResetReq && !busy_r |-> since_r >= 13'hc00 && since_r <= 13'hc12)
        else $error("default timeout off");
endmodule // counter_array_watchdog_chk
bind counter_array_watchdog counter_array_watchdog_chk chk_u (.clk_sys, .rst_n, .regAddr, .regWrEn,
    .regWrData, .regRdEn, .bitWrEn, .bitIdx, .bitVal, .regRdData, .wdResetReq);

//--- tb/test_counter_array_watchdog.sv
// Purpose: Self-checking bench for the counter array watchdog
// Assumes: Inputs change on the falling edge
// Notes: A locked watchdog is only freed by the reset task
`timescale 1ns/10ps
module test_counter_array_watchdog import wdog_pkg::*;;
    logic clk_sys = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, bitWrEn = 1'b0, bitVal = 1'b0;
    logic timer0Ovf = 1'b0, extInPin = 1'b1, extClkPin = 1'b0, cpuIdle = 1'b0, irqReq, wdResetReq;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
    logic [2:0] bitIdx = 3'h0, matchIntEn = 3'h1;
    logic [1:0] moduleMatch = 2'h0;
    int err_count = 0, n_checks = 0, cyc = 0, n;
    counter_array_watchdog dut_u (.clk_sys, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdEn, .bitWrEn,
        .bitIdx, .bitVal, .moduleMatch, .matchIntEn, .timer0Ovf, .extInPin, .extClkPin, .cpuIdle,
        .regRdData, .irqReq, .wdResetReq);
    initial forever #2.5 clk_sys = ~clk_sys;
    // Hang guard, well above the summed test lengths
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            print_verdict;
        end
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Each bus task starts on a fresh falling edge, so strobes never clash
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
    endtask
    task automatic bw(input logic [2:0] i, input logic v);
        @(negedge clk_sys);
        bitIdx = i;
        bitVal = v;
        bitWrEn = 1'b1;
        @(negedge clk_sys);
        bitWrEn = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        d = regRdData;
        chk("read", {a, d}, {a, exp});
    endtask
    task automatic waitRst(input int lim);
        n = 0;
        while (n < lim && wdResetReq !== 1'b1)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic doReset;
        rst_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
    endtask
    task automatic t_defaults;
        doReset;
        waitRst(16'hc80);
        chk("default timeout", n >= 16'hc00 && n <= 16'hc08, 1'b1);
        @(negedge clk_sys);
        chk("pulse end", wdResetReq, 1'b0);
        rdchk(MODE_ADDR, 8'h40);
        rdchk(CTRL_ADDR, 8'h00);
        rdchk(OFFS_ADDR, 8'h00);
        rdchk(8'h00, 8'h00);
        $display("t_defaults done");
    endtask
    // Pulse stands in the cycle right after the bit write edge
    task automatic t_force;
        doReset;
        bw(3'h2, 1'b1);
        chk("forced pulse", wdResetReq, 1'b1);
        @(negedge clk_sys);
        chk("forced end", wdResetReq, 1'b0);
        bw(3'h6, 1'b1); // Module 2 flag still set, another bit written
        chk("no stray force", wdResetReq, 1'b0);
        $display("t_force done");
    endtask
    task automatic t_counter;
        doReset;
        wr(MODE_ADDR, 8'h00);
        rdchk(MODE_ADDR, 8'h00);
        wr(MODE_ADDR, 8'h09); // System clock timebase, overflow interrupt on
        wr(OFFS_ADDR, 8'h80); // Keeps the module 2 match away
        wr(CTRL_ADDR, 8'h38);
        rdchk(CTRL_ADDR, 8'h00);
        wr(CNTL_ADDR, 8'hff);
        wr(CNTH_ADDR, 8'hff);
        repeat (8) @(negedge clk_sys);
        rdchk(CNTL_ADDR, 8'hff);
        bw(3'h6, 1'b1);
        repeat (8) @(negedge clk_sys);
        rdchk(CTRL_ADDR, 8'hc0);
        chk("overflow irq", irqReq, 1'b1);
        bw(3'h7, 1'b0);
        rdchk(CTRL_ADDR, 8'h40);
        chk("irq clear", irqReq, 1'b0);
        @(negedge clk_sys);
        moduleMatch = 2'h1;
        @(negedge clk_sys);
        moduleMatch = 2'h0;
        rdchk(CTRL_ADDR, 8'h41);
        chk("match irq", irqReq, 1'b1);
        bw(3'h0, 1'b0);
        rdchk(CTRL_ADDR, 8'h40);
        wr(MODE_ADDR, 8'h49);
        rdchk(MODE_ADDR, 8'h49);
        wr(MODE_ADDR, 8'hcf);
        rdchk(MODE_ADDR, 8'h49);
        wr(CNTH_ADDR, 8'h55);
        rdchk(CNTH_ADDR, 8'h00);
        $display("t_counter done");
    endtask
    task automatic t_lock;
        doReset;
        wr(MODE_ADDR, 8'h00);
        wr(MODE_ADDR, 8'h20);
        rdchk(MODE_ADDR, 8'h60);
        wr(MODE_ADDR, 8'h00);
        rdchk(MODE_ADDR, 8'h60);
        $display("t_lock done");
    endtask
    // Offset 2 from a near-zero low byte: about 767 counter ticks to the reset
    task automatic t_offset;
        doReset;
        wr(MODE_ADDR, 8'h00);
        wr(MODE_ADDR, 8'h08);
        wr(OFFS_ADDR, 8'h02);
        wr(MODE_ADDR, 8'h48);
        wr(CMPH_ADDR, 8'ha5);
        rdchk(CMPH_ADDR, 8'h02);
        waitRst(16'h384);
        chk("offset timeout", n >= 16'h2f3 && n <= 16'h307, 1'b1);
        $display("t_offset done");
    endtask
    // Other timebases, idle suspend, module 1 and 2 flags; first tick at zero matches module 2
    task automatic t_sources;
        doReset;
        wr(MODE_ADDR, 8'h00);
        wr(MODE_ADDR, 8'h04); // Timer overflow timebase
        bw(3'h6, 1'b1);
        repeat (3)
        begin
            @(negedge clk_sys);
            timer0Ovf = 1'b1;
            @(negedge clk_sys);
            timer0Ovf = 1'b0;
        end
        rdchk(CNTL_ADDR, 8'h03);
        wr(MODE_ADDR, 8'h06); // Falling pin edges, synchroniser adds latency
        repeat (2)
        begin
            @(negedge clk_sys);
            extInPin = 1'b0;
            repeat (4) @(negedge clk_sys);
            extInPin = 1'b1;
            repeat (4) @(negedge clk_sys);
        end
        rdchk(CNTL_ADDR, 8'h05);
        wr(MODE_ADDR, 8'h0a); // External clock over eight, any prescaler start gives two
        repeat (16)
        begin
            @(negedge clk_sys);
            extClkPin = 1'b1;
            repeat (2) @(negedge clk_sys);
            extClkPin = 1'b0;
            repeat (2) @(negedge clk_sys);
        end
        rdchk(CNTL_ADDR, 8'h07);
        cpuIdle = 1'b1;
        wr(MODE_ADDR, 8'h88); // System clock, suspended in idle
        repeat (4) @(negedge clk_sys);
        rdchk(CNTL_ADDR, 8'h07);
        cpuIdle = 1'b0;
        matchIntEn = 3'h2;
        moduleMatch = 2'h2;
        @(negedge clk_sys);
        moduleMatch = 2'h0;
        rdchk(CTRL_ADDR, 8'h46);
        chk("module 1 irq", irqReq, 1'b1);
        matchIntEn = 3'h1;
        $display("t_sources done");
    endtask
    initial
    begin
        t_defaults;
        t_force;
        t_counter;
        t_lock;
        t_offset;
        t_sources;
        print_verdict;
    end
endmodule // test_counter_array_watchdog
